//--- hdl/fgp_exec.sv
// execution of the channel, console, timer, pass and local-memory instruction group
// assumes issue logic presents one opcode with a valid and takes it when ready is high
//
// Function
// - poll opcodes send call pulse plus blank word
// - busy until pulse returns, then capture next word
// - send function: pulse, A, B; busy until reply
// - console read into A/B clears input full
// - input full flag visible to processor test
// - console write loads word, sets full, transmits
// - transmit end clears output full, flag visible
// - timer read copies count, counter keeps running
// - console/timer read destination busy three periods
// - pass opcodes change nothing, no interlock
// - A-addressed load into A; A 6, memory 4
// - A-addressed store of A; memory busy 4
// - B-addressed load into A; needs A,B,memory
// - B-addressed store of A; needs A,B,memory
// - A-addressed load into B
// - that load: B 6, memory 4, A 1
// - stores release source register after one period
// - next instruction may issue one period later
module fgp_exec #(
  parameter int ADDR_W = fgp_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic                                      core_clk_i,
  input  wire logic                                      rst_b_i,
  // instruction issue
  input  wire logic                                      instr_vld_i,
  input  wire logic [7:0]                                instr_op_i,
  output logic                                           issue_ready_o,
  // results of other units written back into A and B
  input  wire logic                                      wb_a_vld_i,
  input  wire logic                                      wb_b_vld_i,
  input  wire logic [31:0]                               wb_data_i,
  // operand registers and interlock state
  output logic [31:0]                                    a_o,
  output logic [31:0]                                    b_o,
  output logic                                           a_free_o,
  output logic                                           b_free_o,
  output logic                                           mem_free_o,
  // channel loops
  output fgp_pkg::fgp_chan_out_t [fgp_pkg::CHANS-1:0]    chan_o,
  input  wire fgp_pkg::fgp_chan_in_t [fgp_pkg::CHANS-1:0] chan_i,
  output logic [fgp_pkg::CHANS-1:0]                      chan_busy_o,
  output logic [fgp_pkg::CHANS-1:0][31:0]                chan_data_o,
  // maintenance console
  input  wire logic                                      cons_in_vld_i,
  input  wire logic [31:0]                               cons_in_data_i,
  output logic                                           cons_in_full_o,
  output logic                                           cons_out_full_o,
  output logic                                           cons_tx_bit_o,
  output logic                                           cons_tx_en_o
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam int HW    = fgp_pkg::HOLD_BUSY_W;
  localparam logic [HW-1:0] HOLD_REG  = HW'(fgp_pkg::HOLD_REG_RD - 1);
  localparam logic [HW-1:0] HOLD_DEST = HW'(fgp_pkg::HOLD_MEM_DEST - 1);
  localparam logic [HW-1:0] HOLD_LM   = HW'(fgp_pkg::HOLD_MEM - 1);
  localparam logic [5:0]    TX_LEN    = 6'(fgp_pkg::TX_BITS);

  typedef struct packed {
    logic [31:0]                               a;
    logic [31:0]                               b;
    logic [31:0]                               asm_word;
    logic [31:0]                               dis_word;
    logic [31:0]                               rtc;
    logic                                      in_full;
    logic                                      out_full;
    logic [5:0]                                tx_left;
    logic                                      tx_bit;
    logic                                      tx_en;
    fgp_pkg::fgp_chan_t [fgp_pkg::CHANS-1:0]   ch;
    logic [DEPTH-1:0][31:0]                    mem;
  } fgp_exec_st_t;

  fgp_exec_st_t st_r;
  fgp_exec_st_t st_nxt;

  logic          need_a;
  logic          need_b;
  logic          need_mem;
  logic          gate_ok;
  logic          fire;
  logic          a_free;
  logic          b_free;
  logic          mem_free;
  logic [HW-1:0] hold_a;
  logic [HW-1:0] hold_b;
  logic [HW-1:0] hold_mem;
  logic [1:0]    sel;
  logic [ADDR_W-1:0] addr_a;
  logic [ADDR_W-1:0] addr_b;

  assign sel    = instr_op_i[1:0];
  assign addr_a = st_r.a[ADDR_W-1:0];
  assign addr_b = st_r.b[ADDR_W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // issue decode and interlock

  always_comb begin
    need_a   = 1'b0;
    need_b   = 1'b0;
    need_mem = 1'b0;
    gate_ok  = 1'b1;
    hold_a   = '0;
    hold_b   = '0;
    hold_mem = '0;
    case (instr_op_i) inside
      [fgp_pkg::OP_SEND_FN_0:fgp_pkg::OP_SEND_FN_3]: begin
        need_a  = 1'b1;
        need_b  = 1'b1;
        gate_ok = !st_r.ch[sel].busy;
      end
      [fgp_pkg::OP_POLL_0:fgp_pkg::OP_POLL_3]: begin
        gate_ok = !st_r.ch[sel].busy;
      end
      fgp_pkg::OP_LD_A_CONS, fgp_pkg::OP_LD_A_TIMER: begin
        need_a = 1'b1;
        hold_a = HOLD_REG;
      end
      fgp_pkg::OP_LD_B_CONS, fgp_pkg::OP_LD_B_TIMER: begin
        need_b = 1'b1;
        hold_b = HOLD_REG;
      end
      fgp_pkg::OP_ST_A_CONS: begin
        need_a  = 1'b1;
        gate_ok = !st_r.out_full;
      end
      fgp_pkg::OP_ST_B_CONS: begin
        need_b  = 1'b1;
        gate_ok = !st_r.out_full;
      end
      fgp_pkg::OP_LD_A_MEM_A: begin
        need_a   = 1'b1;
        need_mem = 1'b1;
        hold_a   = HOLD_DEST;
        hold_mem = HOLD_LM;
      end
      fgp_pkg::OP_ST_A_MEM_A: begin
        need_a   = 1'b1;
        need_mem = 1'b1;
        hold_mem = HOLD_LM;
      end
      fgp_pkg::OP_LD_A_MEM_B: begin
        need_a   = 1'b1;
        need_b   = 1'b1;
        need_mem = 1'b1;
        hold_a   = HOLD_DEST;
        hold_mem = HOLD_LM;
      end
      fgp_pkg::OP_ST_A_MEM_B: begin
        need_a   = 1'b1;
        need_b   = 1'b1;
        need_mem = 1'b1;
        hold_mem = HOLD_LM;
      end
      fgp_pkg::OP_LD_B_MEM_A: begin
        need_a   = 1'b1;
        need_b   = 1'b1;
        need_mem = 1'b1;
        hold_b   = HOLD_DEST;
        hold_mem = HOLD_LM;
      end
      default: begin
      end
    endcase
    // sources of stores carry no hold, so they are free again next cycle
    issue_ready_o = (!need_a || a_free) && (!need_b || b_free) && (!need_mem || mem_free) && gate_ok;
  end

  // one issue per cycle at most; nothing in the group occupies the issue slot longer
  assign fire = instr_vld_i && issue_ready_o;

  fgp_busy_ctr #(.CNT_W(HW)) u_busy_a (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .load_i     (fire),
    .hold_i     (hold_a),
    .free_o     (a_free)
  );

  fgp_busy_ctr #(.CNT_W(HW)) u_busy_b (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .load_i     (fire),
    .hold_i     (hold_b),
    .free_o     (b_free)
  );

  fgp_busy_ctr #(.CNT_W(HW)) u_busy_mem (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .load_i     (fire),
    .hold_i     (hold_mem),
    .free_o     (mem_free)
  );

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt     = st_r;
    st_nxt.rtc = st_r.rtc + 32'h0000_0001;
    if (wb_a_vld_i) begin
      st_nxt.a = wb_data_i;
    end
    if (wb_b_vld_i) begin
      st_nxt.b = wb_data_i;
    end
    // console transmitter, low bit first
    st_nxt.tx_en = 1'b0;
    if (st_r.tx_left != '0) begin
      st_nxt.tx_bit   = st_r.dis_word[0];
      st_nxt.tx_en    = 1'b1;
      st_nxt.dis_word = {1'b0, st_r.dis_word[31:1]};
      st_nxt.tx_left  = st_r.tx_left - 6'h01;
      if (st_r.tx_left == 6'h01) begin
        st_nxt.out_full = 1'b0;
      end
    end
    for (int i = 0; i < fgp_pkg::CHANS; i++) begin
      st_nxt.ch[i].out = '0;
      case (st_r.ch[i].st)
        fgp_pkg::CH_WORD1: begin
          st_nxt.ch[i].out.vld  = 1'b1;
          st_nxt.ch[i].out.word = st_r.ch[i].w1;
          st_nxt.ch[i].st       = st_r.ch[i].is_fn ? fgp_pkg::CH_WORD2 : fgp_pkg::CH_WAIT_RET;
        end
        fgp_pkg::CH_WORD2: begin
          st_nxt.ch[i].out.vld  = 1'b1;
          st_nxt.ch[i].out.word = st_r.ch[i].w2;
          st_nxt.ch[i].st       = fgp_pkg::CH_WAIT_WORD;
        end
        fgp_pkg::CH_WAIT_RET: begin
          if (chan_i[i].ret) begin
            st_nxt.ch[i].st = fgp_pkg::CH_WAIT_WORD;
          end
        end
        fgp_pkg::CH_WAIT_WORD: begin
          // for a poll this word is whatever an answering node put in place of the blank
          if (chan_i[i].vld) begin
            st_nxt.ch[i].data = chan_i[i].word;
            st_nxt.ch[i].busy = 1'b0;
            st_nxt.ch[i].st   = fgp_pkg::CH_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
    if (fire) begin
      case (instr_op_i) inside
        [fgp_pkg::OP_SEND_FN_0:fgp_pkg::OP_SEND_FN_3]: begin
          st_nxt.ch[sel].busy     = 1'b1;
          st_nxt.ch[sel].is_fn    = 1'b1;
          st_nxt.ch[sel].w1       = st_r.a;
          st_nxt.ch[sel].w2       = st_r.b;
          st_nxt.ch[sel].out.func = 1'b1;
          st_nxt.ch[sel].st       = fgp_pkg::CH_WORD1;
        end
        [fgp_pkg::OP_POLL_0:fgp_pkg::OP_POLL_3]: begin
          st_nxt.ch[sel].busy     = 1'b1;
          st_nxt.ch[sel].is_fn    = 1'b0;
          st_nxt.ch[sel].w1       = fgp_pkg::BLANK_WORD;
          st_nxt.ch[sel].out.call = 1'b1;
          st_nxt.ch[sel].st       = fgp_pkg::CH_WORD1;
        end
        fgp_pkg::OP_LD_A_CONS: begin
          st_nxt.a       = st_r.asm_word;
          st_nxt.in_full = 1'b0;
        end
        fgp_pkg::OP_LD_B_CONS: begin
          st_nxt.b       = st_r.asm_word;
          st_nxt.in_full = 1'b0;
        end
        fgp_pkg::OP_ST_A_CONS, fgp_pkg::OP_ST_B_CONS: begin
          st_nxt.dis_word = instr_op_i[3] ? st_r.b : st_r.a;
          st_nxt.out_full = 1'b1;
          st_nxt.tx_left  = TX_LEN;
        end
        fgp_pkg::OP_LD_A_TIMER: st_nxt.a = st_r.rtc;
        fgp_pkg::OP_LD_B_TIMER: st_nxt.b = st_r.rtc;
        fgp_pkg::OP_LD_A_MEM_A: st_nxt.a = st_r.mem[addr_a];
        fgp_pkg::OP_ST_A_MEM_A: st_nxt.mem[addr_a] = st_r.a;
        fgp_pkg::OP_LD_A_MEM_B: st_nxt.a = st_r.mem[addr_b];
        fgp_pkg::OP_ST_A_MEM_B: st_nxt.mem[addr_b] = st_r.a;
        fgp_pkg::OP_LD_B_MEM_A: st_nxt.b = st_r.mem[addr_a];
        default: begin
          // pass opcodes and anything outside the group leave all state alone
        end
      endcase
    end
    // a console word arriving as the flag is read and cleared still sets it
    if (cons_in_vld_i) begin
      st_nxt.asm_word = cons_in_data_i;
      st_nxt.in_full  = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign a_o             = st_r.a;
  assign b_o             = st_r.b;
  assign a_free_o        = a_free;
  assign b_free_o        = b_free;
  assign mem_free_o      = mem_free;
  assign cons_in_full_o  = st_r.in_full;
  assign cons_out_full_o = st_r.out_full;
  assign cons_tx_bit_o   = st_r.tx_bit;
  assign cons_tx_en_o    = st_r.tx_en;

  for (genvar g = 0; g < fgp_pkg::CHANS; g++) begin : g_chan
    assign chan_o[g]      = st_r.ch[g].out;
    assign chan_busy_o[g] = st_r.ch[g].busy;
    assign chan_data_o[g] = st_r.ch[g].data;
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_issue(logic [7:0] op);
    fire && (instr_op_i == op);
  endsequence

  sequence s_poll_ch0;
    fire && (instr_op_i == fgp_pkg::OP_POLL_0);
  endsequence

  a_poll_pulse_word: assert property (s_poll_ch0 |=> chan_o[0].call && !chan_o[0].vld ##1 chan_o[0].vld && chan_o[0].word == fgp_pkg::BLANK_WORD && chan_busy_o[0])
    else $error("poll did not send pulse then blank word");
  a_poll_no_overlap: assert property (fire && instr_op_i inside {[fgp_pkg::OP_POLL_0:fgp_pkg::OP_POLL_3]} |-> !chan_busy_o[sel])
    else $error("poll issued on busy channel");
  a_chan_capture: assert property (st_r.ch[1].st == fgp_pkg::CH_WAIT_WORD && chan_i[1].vld |=> !chan_busy_o[1] && chan_data_o[1] == $past(chan_i[1].word))
    else $error("channel reply not captured");
  a_cons_rd_clear: assert property (s_issue(fgp_pkg::OP_LD_A_CONS) |=> cons_in_full_o == $past(cons_in_vld_i) && a_o == $past(st_r.asm_word))
    else $error("console read did not clear input full");
  a_cons_tx_len: assert property (s_issue(fgp_pkg::OP_ST_B_CONS) |=> cons_out_full_o ##31 cons_out_full_o && cons_tx_en_o ##1 !cons_out_full_o)
    else $error("console transmit length wrong");
  a_timer_hold: assert property (s_issue(fgp_pkg::OP_LD_A_TIMER) |=> !a_free_o [*2] ##1 a_free_o)
    else $error("timer read hold on A wrong");
  a_timer_value: assert property (s_issue(fgp_pkg::OP_LD_B_TIMER) && !wb_b_vld_i |=> b_o == st_r.rtc - 32'h0000_0001)
    else $error("timer read value wrong");
  a_pass_quiet: assert property (s_issue(fgp_pkg::OP_PASS_1) && !wb_a_vld_i && !wb_b_vld_i |=> $stable(a_o) && $stable(b_o))
    else $error("pass changed a register");
  a_mem_ld_hold: assert property (s_issue(fgp_pkg::OP_LD_B_MEM_A) |=> a_free_o && !mem_free_o [*3] ##1 mem_free_o && !b_free_o ##2 b_free_o)
    else $error("load into B hold times wrong");
  a_load_a_hold: assert property (s_issue(fgp_pkg::OP_LD_A_MEM_A) |=> !a_free_o [*5] ##1 a_free_o)
    else $error("load into A hold wrong");
  a_store_release: assert property (s_issue(fgp_pkg::OP_ST_A_MEM_B) |=> a_free_o && b_free_o && !mem_free_o)
    else $error("store did not release sources");

endmodule : fgp_exec

//--- hdl/fgp_pkg.sv
// shared constants and carrier types for the foreground processor execution group
// assumes one processor clock and a synchronous active-low reset in every user
package fgp_pkg;

  localparam int DATA_W = 32;
  localparam int CHANS  = 4;
  localparam int ADDR_W = 12;

  // opcodes of the group, plus the transmit-function range that shares the channels
  localparam logic [7:0] OP_SEND_FN_0   = 8'h28;
  localparam logic [7:0] OP_SEND_FN_3   = 8'h2B;
  localparam logic [7:0] OP_POLL_0      = 8'h2C;
  localparam logic [7:0] OP_POLL_3      = 8'h2F;
  localparam logic [7:0] OP_LD_A_CONS   = 8'h30;
  localparam logic [7:0] OP_ST_A_CONS   = 8'h31;
  localparam logic [7:0] OP_LD_A_TIMER  = 8'h32;
  localparam logic [7:0] OP_PASS_0      = 8'h33;
  localparam logic [7:0] OP_LD_A_MEM_A  = 8'h34;
  localparam logic [7:0] OP_ST_A_MEM_A  = 8'h35;
  localparam logic [7:0] OP_LD_A_MEM_B  = 8'h36;
  localparam logic [7:0] OP_ST_A_MEM_B  = 8'h37;
  localparam logic [7:0] OP_LD_B_CONS   = 8'h38;
  localparam logic [7:0] OP_ST_B_CONS   = 8'h39;
  localparam logic [7:0] OP_LD_B_TIMER  = 8'h3A;
  localparam logic [7:0] OP_PASS_1      = 8'h3B;
  localparam logic [7:0] OP_LD_B_MEM_A  = 8'h3C;

  // resource hold times in clock periods after issue
  localparam int HOLD_REG_RD   = 3;
  localparam int HOLD_MEM_DEST = 6;
  localparam int HOLD_MEM      = 4;
  localparam int HOLD_BUSY_W   = 3;

  // console serial output length in bits
  localparam int TX_BITS = 32;

  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] BLANK_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {CH_IDLE, CH_WORD1, CH_WORD2, CH_WAIT_RET, CH_WAIT_WORD} fgp_ch_state_t;

  typedef struct packed {
    logic        call;
    logic        func;
    logic        vld;
    logic [31:0] word;
  } fgp_chan_out_t;

  typedef struct packed {
    logic        ret;
    logic        vld;
    logic [31:0] word;
  } fgp_chan_in_t;

  typedef struct packed {
    fgp_ch_state_t st;
    logic          busy;
    logic          is_fn;
    logic [31:0]   data;
    logic [31:0]   w1;
    logic [31:0]   w2;
    fgp_chan_out_t out;
  } fgp_chan_t;

endpackage : fgp_pkg

//--- hdl/fgp_busy_ctr.sv
// busy countdown for one interlocked resource (A, B or local memory)
// assumes load values are the extra cycles beyond the first after issue
module fgp_busy_ctr #(
  parameter int CNT_W = 3
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  // hold request from issue
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] hold_i,
  // status
  output logic                  free_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } fgp_busy_st_t;

  fgp_busy_st_t st_r;
  fgp_busy_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // a shorter hold never cuts an earlier longer one short
    if (load_i && (hold_i > st_r.cnt)) begin
      st_nxt.cnt = hold_i;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign free_o = (st_r.cnt == '0);

endmodule : fgp_busy_ctr

//--- verification/fgp_node_model.sv
// behavioural channel loop nodes and console receiver facing fgp_exec
// assumes chan_o_i and tx lines come from fgp_exec on the same clock
module fgp_node_model (
  // clock and reset
  input  wire logic                                        core_clk_i,
  input  wire logic                                        rst_b_i,
  // channel loops
  input  wire fgp_pkg::fgp_chan_out_t [fgp_pkg::CHANS-1:0] chan_o_i,
  output fgp_pkg::fgp_chan_in_t [fgp_pkg::CHANS-1:0]       chan_i_o,
  input  wire logic                                        slow_i,
  // console serial line
  input  wire logic                                        tx_bit_i,
  input  wire logic                                        tx_en_i,
  output logic [31:0]                                      rx_word_o
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  for (genvar c = 0; c < fgp_pkg::CHANS; c++) begin : g_node
    logic [31:0] resp_r;
    logic [31:0] fn_w;

    // idle word is the inverse of the last one so a stale capture shows up
    task automatic send_word(input logic [31:0] w);
      repeat (slow_i ? 6 : 1) @(posedge core_clk_i);
      chan_i_o[c].vld  <= 1'b1;
      chan_i_o[c].word <= w;
      @(posedge core_clk_i);
      chan_i_o[c].vld  <= 1'b0;
      chan_i_o[c].word <= ~w;
    endtask : send_word

    initial begin
      resp_r = 32'h0000_0000;
      chan_i_o[c] = '0;
      forever begin
        @(posedge core_clk_i);
        if (chan_o_i[c].func) begin
          @(posedge core_clk_i);
          fn_w = chan_o_i[c].word;
          @(posedge core_clk_i);
          resp_r = chan_o_i[c].word;
          send_word(~fn_w);
        end else if (chan_o_i[c].call) begin
          @(posedge core_clk_i);
          repeat (slow_i ? 5 : 1) @(posedge core_clk_i);
          chan_i_o[c].ret <= 1'b1;
          @(posedge core_clk_i);
          chan_i_o[c].ret <= 1'b0;
          send_word(resp_r);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // console bits arrive lsb first
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rx_word_o <= 32'h0000_0000;
    end else if (tx_en_i) begin
      rx_word_o <= {tx_bit_i, rx_word_o[31:1]};
    end
  end
endmodule : fgp_node_model

//--- verification/fgp_exec_test.sv
// self-checking bench for the execution group: memory, console, timer, pass, channels
// assumes fgp_exec with a 4-bit memory address and the behavioural node model
module fgp_exec_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                                        core_clk_i;
  logic                                        rst_b_i;
  logic                                        instr_vld_i;
  logic [7:0]                                  instr_op_i;
  logic                                        issue_ready_o;
  logic                                        wb_a_vld_i;
  logic                                        wb_b_vld_i;
  logic [31:0]                                 wb_data_i;
  logic [31:0]                                 a_o;
  logic [31:0]                                 b_o;
  logic                                        a_free_o;
  logic                                        b_free_o;
  logic                                        mem_free_o;
  fgp_pkg::fgp_chan_out_t [fgp_pkg::CHANS-1:0] chan_o;
  fgp_pkg::fgp_chan_in_t [fgp_pkg::CHANS-1:0]  chan_i;
  logic [fgp_pkg::CHANS-1:0]                   chan_busy_o;
  logic [fgp_pkg::CHANS-1:0][31:0]             chan_data_o;
  logic                                        cons_in_vld_i;
  logic [31:0]                                 cons_in_data_i;
  logic                                        cons_in_full_o;
  logic                                        cons_out_full_o;
  logic                                        cons_tx_bit_o;
  logic                                        cons_tx_en_o;
  logic                                        slow;
  logic [31:0]                                 rx_word;
  int                                          fail_count;
  int                                          comparisons;

  fgp_exec #(.ADDR_W(4)) u_dut (
    .core_clk_i, .rst_b_i, .instr_vld_i, .instr_op_i, .issue_ready_o,
    .wb_a_vld_i, .wb_b_vld_i, .wb_data_i, .a_o, .b_o, .a_free_o, .b_free_o, .mem_free_o,
    .chan_o, .chan_i, .chan_busy_o, .chan_data_o, .cons_in_vld_i, .cons_in_data_i,
    .cons_in_full_o, .cons_out_full_o, .cons_tx_bit_o, .cons_tx_en_o
  );

  fgp_node_model u_node (
    .core_clk_i, .rst_b_i, .chan_o_i(chan_o), .chan_i_o(chan_i), .slow_i(slow),
    .tx_bit_i(cons_tx_bit_o), .tx_en_i(cons_tx_en_o), .rx_word_o(rx_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // keep leaves valid up so a second op can follow on the very next edge
  task automatic issue(input logic [7:0] op, input bit keep, output int waits);
    waits = 0;
    instr_vld_i <= 1'b1;
    instr_op_i  <= op;
    @(negedge core_clk_i);
    while (issue_ready_o !== 1'b1 && waits < 100) begin
      waits++;
      @(negedge core_clk_i);
    end
    check("issue ready", waits < 100, 1);
    @(posedge core_clk_i);
    if (!keep) begin
      instr_vld_i <= 1'b0;
    end
  endtask : issue

  task automatic load_ab(input logic [31:0] a, input logic [31:0] b);
    wb_a_vld_i <= 1'b1;
    wb_data_i  <= a;
    @(posedge core_clk_i);
    wb_a_vld_i <= 1'b0;
    wb_b_vld_i <= 1'b1;
    wb_data_i  <= b;
    @(posedge core_clk_i);
    wb_b_vld_i <= 1'b0;
  endtask : load_ab

  // counts busy cycles after an issue; a resource free at period h is low h-1 cycles
  task automatic holds(input string what, input int ha, input int hb, input int hm);
    int na = 0, nb = 0, nm = 0;
    repeat (7) begin
      @(negedge core_clk_i);
      na += int'(a_free_o !== 1'b1);
      nb += int'(b_free_o !== 1'b1);
      nm += int'(mem_free_o !== 1'b1);
    end
    @(posedge core_clk_i);
    check({what, " a"}, na, ha - 1);
    check({what, " b"}, nb, hb - 1);
    check({what, " mem"}, nm, hm - 1);
  endtask : holds

  task automatic wait_idle(input int c);
    int n;
    n = 0;
    while (chan_busy_o[c] !== 1'b0 && n < 50) begin
      n++;
      @(negedge core_clk_i);
    end
    check("chan idle", n < 50, 1);
    @(posedge core_clk_i);
  endtask : wait_idle

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_memory();
    int w;
    load_ab(32'h0001_0005, 32'h0000_0005);
    issue(fgp_pkg::OP_ST_A_MEM_A, 0, w);
    holds("st by a", 1, 1, 4);
    load_ab(32'hABCD_0003, 32'h0000_0005);
    issue(fgp_pkg::OP_ST_A_MEM_B, 0, w);
    holds("st by b", 1, 1, 4);
    load_ab(32'h0002_0005, 32'h0000_0000);
    issue(fgp_pkg::OP_LD_A_MEM_A, 0, w);
    holds("ld a by a", 6, 1, 4);
    check("ld a by a", a_o, 32'hABCD_0003);
    load_ab(32'h0000_0005, 32'h0000_0000);
    issue(fgp_pkg::OP_LD_B_MEM_A, 0, w);
    holds("ld b by a", 1, 6, 4);
    check("ld b by a", b_o, 32'hABCD_0003);
    load_ab(32'h0000_0000, 32'h0001_0005);
    issue(fgp_pkg::OP_LD_A_MEM_B, 0, w);
    holds("ld a by b", 6, 1, 4);
    check("ld a by b", a_o, 32'hABCD_0003);
    issue(fgp_pkg::OP_LD_A_MEM_A, 1, w);
    issue(fgp_pkg::OP_ST_A_MEM_A, 0, w);
    check("store behind load", w, 5);
  endtask : test_memory

  task automatic test_console();
    int w;
    for (int i = 0; i < 2; i++) begin
      cons_in_vld_i  <= 1'b1;
      cons_in_data_i <= 32'h1234_5670 + i;
      @(posedge core_clk_i);
      cons_in_vld_i <= 1'b0;
      @(negedge core_clk_i);
      check("in full", cons_in_full_o, 1);
      @(posedge core_clk_i);
      issue(i ? fgp_pkg::OP_LD_B_CONS : fgp_pkg::OP_LD_A_CONS, 0, w);
      holds("cons rd", i ? 1 : 3, i ? 3 : 1, 1);
      check("cons rd", i ? b_o : a_o, 32'h1234_5670 + i);
      check("in full clr", cons_in_full_o, 0);
    end
    load_ab(32'h8000_00F1, 32'h0F00_0A5C);
    issue(fgp_pkg::OP_ST_A_CONS, 0, w);
    holds("cons wr", 1, 1, 1);
    check("out full", cons_out_full_o, 1);
    issue(fgp_pkg::OP_ST_B_CONS, 0, w);
    check("wr stall", w, fgp_pkg::TX_BITS - 7);
    @(negedge core_clk_i);
    check("tx a", rx_word, 32'h8000_00F1);
    repeat (fgp_pkg::TX_BITS + 1) @(posedge core_clk_i);
    @(negedge core_clk_i);
    check("out full clr", cons_out_full_o, 0);
    check("tx b", rx_word, 32'h0F00_0A5C);
    @(posedge core_clk_i);
  endtask : test_console

  task automatic test_timer_pass();
    int w;
    logic [31:0] sa;
    logic [31:0] sb;
    issue(fgp_pkg::OP_LD_A_TIMER, 1, w);
    issue(fgp_pkg::OP_LD_B_TIMER, 0, w);
    @(negedge core_clk_i);
    check("timer step", b_o - a_o, 1);
    sa = a_o;
    sb = b_o;
    @(posedge core_clk_i);
    issue(fgp_pkg::OP_ST_A_MEM_A, 1, w);
    issue(fgp_pkg::OP_PASS_0, 1, w);
    check("pass 0 wait", w, 0);
    issue(fgp_pkg::OP_PASS_1, 0, w);
    check("pass 1 wait", w, 0);
    @(negedge core_clk_i);
    check("pass a", a_o, sa);
    check("pass b", b_o, sb);
    check("pass flags", {chan_busy_o, cons_in_full_o, cons_out_full_o}, 0);
    @(posedge core_clk_i);
  endtask : test_timer_pass

  // odd channels get a slow node so the busy window is long
  task automatic test_channels();
    int w;
    for (int c = 0; c < fgp_pkg::CHANS; c++) begin
      slow <= c[0];
      load_ab(32'h0000_0100 + c, 32'hC0DE_0000 + c);
      issue(8'(fgp_pkg::OP_SEND_FN_0 + c), 0, w);
      @(negedge core_clk_i);
      check("fn pulse", {chan_o[c].func, chan_busy_o[c]}, 2'b11);
      @(negedge core_clk_i);
      check("fn word a", chan_o[c].word, 32'h0000_0100 + c);
      @(negedge core_clk_i);
      check("fn word b", chan_o[c].word, 32'hC0DE_0000 + c);
      wait_idle(c);
      check("fn reply", chan_data_o[c], ~(32'h0000_0100 + c));
      issue(8'(fgp_pkg::OP_POLL_0 + c), 1, w);
      @(negedge core_clk_i);
      check("call pulse", {chan_o[c].call, chan_busy_o[c]}, 2'b11);
      check("repoll held", issue_ready_o, 0);
      @(negedge core_clk_i);
      check("blank vld", chan_o[c].vld, 1);
      check("blank word", chan_o[c].word, fgp_pkg::BLANK_WORD);
      @(posedge core_clk_i);
      instr_vld_i <= 1'b0;
      wait_idle(c);
      check("poll data", chan_data_o[c], 32'hC0DE_0000 + c);
    end
  endtask : test_channels

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  initial begin
    fail_count = 0;
    comparisons = 0;
    rst_b_i = 1'b0;
    instr_vld_i = 1'b0;
    instr_op_i = 8'h00;
    wb_a_vld_i = 1'b0;
    wb_b_vld_i = 1'b0;
    wb_data_i = 32'h0000_0000;
    cons_in_vld_i = 1'b0;
    cons_in_data_i = 32'h0000_0000;
    slow = 1'b0;
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    test_memory();
    test_console();
    test_timer_pass();
    test_channels();
    wrap_up();
  end

  // whole run needs well under a thousand cycles; five times that means a hang
  initial begin
    repeat (5000) @(posedge core_clk_i);
    fail_count++;
    wrap_up();
  end
endmodule : fgp_exec_test
